// *** shared/but_pkg.sv ***
// Purpose: constants for the basic up-counting timer
// Assumes: axi4-lite, 32-bit data, byte addresses
// Notes: offsets are byte addresses of aligned words
package but_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_CONTROL1 = 8'h04;
  localparam logic [7:0] OFF_DMAINTEN = 8'h0C;
  localparam logic [7:0] OFF_FLAG = 8'h10;
  localparam logic [7:0] OFF_SWEVENT = 8'h14;
  localparam logic [7:0] OFF_COUNT = 8'h24;
  localparam logic [7:0] OFF_PRESCALE = 8'h28;
  localparam logic [7:0] OFF_RELOAD = 8'h2C;
  localparam logic [7:0] OFF_DEBUG = 8'h30;
  // ==========================================================
  // field positions
  localparam int BIT_COUNT_EN = 0;
  localparam int BIT_UPD_INHIBIT = 1;
  localparam int BIT_UPD_SOURCE = 2;
  localparam int BIT_ONE_SHOT = 3;
  localparam int BIT_RELOAD_BUF = 7;
  localparam int BIT_IRQ_EN = 0;
  localparam int BIT_DMA_EN = 8;
  localparam int BIT_UPD_FLAG = 0;
  localparam int BIT_FORCE_UPD = 0;
  localparam int BIT_FREEZE = 0;
  localparam int TRG_SEL_LSB = 4;
  // ==========================================================
  // reset values, trigger select codes and response codes
  localparam logic [15:0] RST_RELOAD = 16'hFFFF;
  localparam logic [15:0] RST_ZERO16 = 16'h0000;
  localparam logic [2:0] TRG_ON_RESET = 3'h0;
  localparam logic [2:0] TRG_ON_START = 3'h1;
  localparam logic [2:0] TRG_ON_UPDATE = 3'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : but_pkg

// *** hw/but_prescaler.sv ***
// Purpose: divides the timer input clock into count ticks
// Assumes: one clock, synchronous active-high reset
// Notes: factor is active value plus one
module but_prescaler #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic clear,
  input wire logic [WIDTH-1:0] divide_value,
  output logic tick
);
  logic [WIDTH-1:0] div_count;
  logic [WIDTH-1:0] next_div_count;

  // refuse a width the divider cannot serve
  if (WIDTH < 1) begin : g_width_check
    $error("prescaler width must be positive");
  end

  always_comb begin
    next_div_count = div_count;
    tick = 1'b0;
    if (clear) begin
      next_div_count = '0;
    end else if (run) begin
      if (div_count >= divide_value) begin
        next_div_count = '0;
        tick = 1'b1;
      end else begin
        next_div_count = div_count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div_count <= '0;
    end else begin
      div_count <= next_div_count;
    end
  end
endmodule : but_prescaler

// *** hw/but_sync.sv ***
// Purpose: three-stage synchroniser for a pin level
// Assumes: input asynchronous to clk
// Notes: output changes once stages two and three agree
module but_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic next_level;

  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule : but_sync

// *** hw/but_timer.sv ***
// Purpose: basic 16-bit up-counting timer with axi4-lite registers
// Assumes: one clock clk, synchronous reset rst
// Notes: update event drives flag, irq, dma request and trigger
//
// Decided for this implementation: the AXI4-Lite register port.
module but_timer #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic core_halted,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  output logic dma_req,
  output logic trigger_output
);
  if (WIDTH != 16) begin : g_width_check
    $error("timer width must be 16");
  end

  // ==========================================================
  // state
  logic [7:0] control;
  logic [2:0] trg_sel;
  logic irq_en;
  logic dma_en;
  logic update_flag;
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] prescale_register;
  logic [WIDTH-1:0] prescale_active;
  logic [WIDTH-1:0] reload_value_register;
  logic [WIDTH-1:0] reload_active;
  logic debug_freeze_bit;
  logic force_update;
  logic halted;
  logic tick;

  logic [7:0] next_control;
  logic [2:0] next_trg_sel;
  logic next_irq_en;
  logic next_dma_en;
  logic next_update_flag;
  logic [WIDTH-1:0] next_count;
  logic [WIDTH-1:0] next_prescale_register;
  logic [WIDTH-1:0] next_prescale_active;
  logic [WIDTH-1:0] next_reload_value_register;
  logic [WIDTH-1:0] next_reload_active;
  logic next_debug_freeze_bit;
  logic next_force_update;
  logic next_irq;
  logic next_dma_req;
  logic next_trigger_output;

  // ==========================================================
  // axi4-lite handshake state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [7:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic wr_go;
  logic rd_go;
  logic aw_have;
  logic w_have;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == but_pkg::OFF_CONTROL) || (a == but_pkg::OFF_CONTROL1) ||
             (a == but_pkg::OFF_DMAINTEN) || (a == but_pkg::OFF_FLAG) ||
             (a == but_pkg::OFF_SWEVENT) || (a == but_pkg::OFF_COUNT) ||
             (a == but_pkg::OFF_PRESCALE) || (a == but_pkg::OFF_RELOAD) ||
             (a == but_pkg::OFF_DEBUG);
  endfunction : mapped

  // only the low half-word is meaningful; upper strobes are ignored
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  // internal clock only; halt with freeze stops ticks
  but_prescaler #(.WIDTH(WIDTH)) u_prescaler (
    .clk(clk),
    .rst(rst),
    .run(control[but_pkg::BIT_COUNT_EN] && !(halted && debug_freeze_bit)),
    .clear(force_update),
    .divide_value(prescale_active),
    .tick(tick)
  );

  but_sync u_halt_sync (
    .clk(clk),
    .rst(rst),
    .pin(core_halted),
    .level(halted)
  );

  // built from registered state and inputs so no loop through next_*
  assign aw_have = aw_held || (s_axi_awvalid && s_axi_awready);
  assign w_have = w_held || (s_axi_wvalid && s_axi_wready);
  assign wr_go = aw_have && w_have && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp = s_axi_bresp;
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = mapped(next_aw_addr) ? but_pkg::RESP_OKAY : but_pkg::RESP_SLVERR;
    end
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = mapped(s_axi_araddr) ? but_pkg::RESP_OKAY : but_pkg::RESP_SLVERR;
      next_rdata = '0;
      unique case (s_axi_araddr)
        but_pkg::OFF_CONTROL: next_rdata[7:0] = control;
        but_pkg::OFF_CONTROL1: next_rdata[but_pkg::TRG_SEL_LSB +: 3] = trg_sel;
        but_pkg::OFF_DMAINTEN: begin
          next_rdata[but_pkg::BIT_IRQ_EN] = irq_en;
          next_rdata[but_pkg::BIT_DMA_EN] = dma_en;
        end
        but_pkg::OFF_FLAG: next_rdata[but_pkg::BIT_UPD_FLAG] = update_flag;
        but_pkg::OFF_COUNT: next_rdata[15:0] = count;
        but_pkg::OFF_PRESCALE: next_rdata[15:0] = prescale_register;
        but_pkg::OFF_RELOAD: next_rdata[15:0] = reload_value_register;
        but_pkg::OFF_DEBUG: next_rdata[but_pkg::BIT_FREEZE] = debug_freeze_bit;
        default: next_rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // timer core
  logic overflow;
  logic update_event;
  logic request_event;
  logic start_event;
  logic wr_ctrl;
  logic [15:0] ctrl_wval;

  always_comb begin
    next_control = control;
    next_trg_sel = trg_sel;
    next_irq_en = irq_en;
    next_dma_en = dma_en;
    next_update_flag = update_flag;
    next_count = count;
    next_prescale_register = prescale_register;
    next_prescale_active = prescale_active;
    next_reload_value_register = reload_value_register;
    next_reload_active = reload_active;
    next_debug_freeze_bit = debug_freeze_bit;
    next_force_update = 1'b0;
    wr_ctrl = wr_go && (next_aw_addr == but_pkg::OFF_CONTROL);
    ctrl_wval = merge16({8'h00, control}, next_w_data, next_w_strb);
    // wrap at reload; unbuffered reload uses register
    overflow = tick && (count >= (control[but_pkg::BIT_RELOAD_BUF] ?
                                  reload_active : reload_value_register));
    // update unless inhibited; inhibit blocks all sources
    update_event = !control[but_pkg::BIT_UPD_INHIBIT] && (overflow || force_update);
    request_event = update_event &&
                    (!control[but_pkg::BIT_UPD_SOURCE] || overflow);
    start_event = wr_ctrl && ctrl_wval[but_pkg::BIT_COUNT_EN] &&
                  !control[but_pkg::BIT_COUNT_EN];
    if (tick) begin
      next_count = overflow ? but_pkg::RST_ZERO16 : count + 1'b1;
    end
    if (force_update) begin
      next_count = but_pkg::RST_ZERO16;
    end
    // shadow copy on update; prescale waits
    if (update_event) begin
      next_prescale_active = prescale_register;
      next_reload_active = reload_value_register;
    end
    if (wr_go) begin
      unique case (next_aw_addr)
        but_pkg::OFF_CONTROL: next_control = ctrl_wval[7:0] & 8'h8F;
        but_pkg::OFF_CONTROL1: begin
          next_trg_sel = next_w_strb[0] ?
                         next_w_data[but_pkg::TRG_SEL_LSB +: 3] : trg_sel;
        end
        but_pkg::OFF_DMAINTEN: begin
          if (next_w_strb[0]) next_irq_en = next_w_data[but_pkg::BIT_IRQ_EN];
          if (next_w_strb[1]) next_dma_en = next_w_data[but_pkg::BIT_DMA_EN];
        end
        but_pkg::OFF_FLAG: begin
          if (next_w_strb[0] && !next_w_data[but_pkg::BIT_UPD_FLAG]) begin
            next_update_flag = 1'b0;
          end
        end
        but_pkg::OFF_SWEVENT: next_force_update = next_w_strb[0] &&
                                                  next_w_data[but_pkg::BIT_FORCE_UPD];
        but_pkg::OFF_COUNT: next_count = merge16(count, next_w_data, next_w_strb);
        but_pkg::OFF_PRESCALE: next_prescale_register =
                                 merge16(prescale_register, next_w_data, next_w_strb);
        but_pkg::OFF_RELOAD: next_reload_value_register =
                               merge16(reload_value_register, next_w_data, next_w_strb);
        but_pkg::OFF_DEBUG: begin
          if (next_w_strb[0]) next_debug_freeze_bit = next_w_data[but_pkg::BIT_FREEZE];
        end
        default: next_count = next_count;
      endcase
    end
    if (!next_control[but_pkg::BIT_RELOAD_BUF]) begin
      next_reload_active = next_reload_value_register;
    end
    if (request_event) begin
      next_update_flag = 1'b1;
    end
    if (update_event && control[but_pkg::BIT_ONE_SHOT]) begin
      next_control[but_pkg::BIT_COUNT_EN] = 1'b0;
      next_count = but_pkg::RST_ZERO16;
    end
    next_irq = irq_en && request_event;
    next_dma_req = dma_en && request_event;
    unique case (trg_sel)
      but_pkg::TRG_ON_RESET: next_trigger_output = force_update;
      but_pkg::TRG_ON_START: next_trigger_output = start_event;
      but_pkg::TRG_ON_UPDATE: next_trigger_output = update_event;
      default: next_trigger_output = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      control <= 8'h00;
      trg_sel <= 3'h0;
      irq_en <= 1'b0;
      dma_en <= 1'b0;
      update_flag <= 1'b0;
      count <= but_pkg::RST_ZERO16;
      prescale_register <= but_pkg::RST_ZERO16;
      prescale_active <= but_pkg::RST_ZERO16;
      reload_value_register <= but_pkg::RST_RELOAD;
      reload_active <= but_pkg::RST_RELOAD;
      debug_freeze_bit <= 1'b0;
      force_update <= 1'b0;
      irq <= 1'b0;
      dma_req <= 1'b0;
      trigger_output <= 1'b0;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      control <= next_control;
      trg_sel <= next_trg_sel;
      irq_en <= next_irq_en;
      dma_en <= next_dma_en;
      update_flag <= next_update_flag;
      count <= next_count;
      prescale_register <= next_prescale_register;
      prescale_active <= next_prescale_active;
      reload_value_register <= next_reload_value_register;
      reload_active <= next_reload_active;
      debug_freeze_bit <= next_debug_freeze_bit;
      force_update <= next_force_update;
      irq <= next_irq;
      dma_req <= next_dma_req;
      trigger_output <= next_trigger_output;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      // a held word blocks its channel until the response leaves
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      s_axi_arready <= !next_rvalid && !rd_go;
    end
  end

  // ==========================================================
  // checks
  a_tick_spacing: assert property (@(posedge clk) disable iff (rst)
    tick && prescale_active != '0 && !update_event |=> !tick)
    else $error("tick too early for factor above one");
  a_wrap_zero: assert property (@(posedge clk) disable iff (rst)
    overflow && !wr_go |=> count == 16'h0000) else $error("no wrap to zero");
  a_inhibit_blocks: assert property (@(posedge clk) disable iff (rst)
    control[but_pkg::BIT_UPD_INHIBIT] && !update_flag |=> !update_flag && !irq && !dma_req)
    else $error("update while inhibited");
  a_force_clears: assert property (@(posedge clk) disable iff (rst)
    force_update && !wr_go |=> count == 16'h0000) else $error("force did not clear");
  a_shadow_load: assert property (@(posedge clk) disable iff (rst)
    update_event |=> prescale_active == $past(prescale_register))
    else $error("prescale shadow not loaded");
  a_one_shot_stop: assert property (@(posedge clk) disable iff (rst)
    update_event && control[3] && !wr_go |=> !control[0])
    else $error("one shot did not stop");
  a_hold_stopped: assert property (@(posedge clk) disable iff (rst)
    !control[0] && !force_update && !wr_go |=> $stable(count))
    else $error("counter moved while disabled");
  a_flag_sets: assert property (@(posedge clk) disable iff (rst)
    request_event |=> update_flag) else $error("flag not set");
  a_irq_gate: assert property (@(posedge clk) disable iff (rst)
    irq |-> $past(irq_en)) else $error("irq without enable");
  a_source_sel: assert property (@(posedge clk) disable iff (rst)
    control[but_pkg::BIT_UPD_SOURCE] && force_update && !overflow |=> !irq && !dma_req)
    else $error("request from force");
  c_overflow: cover property (@(posedge clk) disable iff (rst) overflow);
  c_force: cover property (@(posedge clk) disable iff (rst) force_update && update_event);
  c_one_shot: cover property (@(posedge clk) disable iff (rst) update_event && control[3]);
endmodule : but_timer

// *** bench/but_timer_tb_top.sv ***
// Purpose: self-checking bench for the basic up-counting timer
// Assumes: axi4-lite master tasks, 125 MHz clock, sync reset
// Notes: count checks use ranges where bus latency blurs the edge
module but_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, core_halted;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdv, v1;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic irq, dma_req, trigger_output;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  int n_irq = 0;
  int n_dma = 0;
  int n_trg = 0;
  int s_irq, s_dma, s_trg;

  but_timer u_but_timer (.clk(clk), .rst(rst), .core_halted(core_halted),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq), .dma_req(dma_req),
    .trigger_output(trigger_output));

  // ==========================================================
  // clock, pulse counters, watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq === 1'b1) n_irq++;
    if (dma_req === 1'b1) n_dma++;
    if (trigger_output === 1'b1) n_trg++;
    cyc++;
    // whole run is well under this; a hung handshake ends here
    if (cyc == 30000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ==========================================================
  // bus tasks and compare
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (s_axi_awready && !aw_ok) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_ok) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic snap();
    s_irq = n_irq;
    s_dma = n_dma;
    s_trg = n_trg;
  endtask : snap

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  // ==========================================================
  // scenarios
  task automatic t_reset();
    rd(but_pkg::OFF_CONTROL);
    chk("control", 32'h0000_0000, rdv);
    chk("rd_okay", {30'h0, but_pkg::RESP_OKAY}, {30'h0, rsp});
    rd(but_pkg::OFF_RELOAD);
    chk("reload", 32'h0000_FFFF, rdv);
    rd(but_pkg::OFF_COUNT);
    chk("count", 32'h0000_0000, rdv);
    rd(8'h40);
    chk("rd_resp", {30'h0, but_pkg::RESP_SLVERR}, {30'h0, rsp});
    chk("rd_unmapped", 32'h0000_0000, rdv);
    wr(8'h40, 32'h0000_0001);
    chk("wr_resp", {30'h0, but_pkg::RESP_SLVERR}, {30'h0, rsp});
  endtask : t_reset

  task automatic t_wrap();
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
    wr(but_pkg::OFF_RELOAD, 32'h0000_0004);
    chk("wr_okay", {30'h0, but_pkg::RESP_OKAY}, {30'h0, rsp});
    wr(but_pkg::OFF_FLAG, 32'h0000_0000);
    rd(but_pkg::OFF_FLAG);
    chk("flag_cleared", 32'h0, rdv);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0001);
    for (int i = 0; i < 8; i++) begin
      rd(but_pkg::OFF_COUNT);
      chk("count_le_reload", 32'h1, {31'h0, rdv <= 32'h4});
    end
    rd(but_pkg::OFF_FLAG);
    chk("flag_on_wrap", 32'h1, rdv);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0000);
  endtask : t_wrap

  task automatic t_prescale();
    wr(but_pkg::OFF_RELOAD, 32'h0000_FFFF);
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
    wr(but_pkg::OFF_PRESCALE, 32'h0000_0003);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0001);
    repeat (20) @(posedge clk);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0000);
    rd(but_pkg::OFF_COUNT);
    v1 = rdv;
    chk("old_factor", 32'h1, {31'h0, rdv >= 32'd20 && rdv <= 32'd28});
    repeat (10) @(posedge clk);
    rd(but_pkg::OFF_COUNT);
    chk("count_held", v1, rdv);
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0001);
    repeat (40) @(posedge clk);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0000);
    rd(but_pkg::OFF_COUNT);
    chk("new_factor", 32'h1, {31'h0, rdv >= 32'd9 && rdv <= 32'd13});
    wr(but_pkg::OFF_PRESCALE, 32'h0000_0000);
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
  endtask : t_prescale

  task automatic t_force();
    wr(but_pkg::OFF_DMAINTEN, 32'h0000_0101);
    wr(but_pkg::OFF_CONTROL1, 32'h0000_0020);
    wr(but_pkg::OFF_COUNT, 32'h0000_0010);
    snap();
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk("irq_pulses", 32'd1, n_irq - s_irq);
    chk("dma_pulses", 32'd1, n_dma - s_dma);
    chk("trg_update", 32'd1, n_trg - s_trg);
    rd(but_pkg::OFF_COUNT);
    chk("count_forced", 32'h0, rdv);
    rd(but_pkg::OFF_SWEVENT);
    chk("force_selfclr", 32'h0, rdv);
    // overflow-only source: software update raises no request
    wr(but_pkg::OFF_CONTROL, 32'h0000_0004);
    wr(but_pkg::OFF_FLAG, 32'h0000_0000);
    snap();
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk("irq_src_ovf", 32'd0, n_irq - s_irq);
    rd(but_pkg::OFF_FLAG);
    chk("flag_src_ovf", 32'h0, rdv);
  endtask : t_force

  task automatic t_inhibit();
    wr(but_pkg::OFF_CONTROL1, 32'h0000_0000);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0002);
    wr(but_pkg::OFF_COUNT, 32'h0000_0010);
    snap();
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
    repeat (4) @(posedge clk);
    rd(but_pkg::OFF_COUNT);
    chk("count_inhib", 32'h0, rdv);
    rd(but_pkg::OFF_FLAG);
    chk("flag_inhib", 32'h0, rdv);
    chk("irq_inhib", 32'd0, n_irq - s_irq);
    chk("trg_reset", 32'd1, n_trg - s_trg);
    wr(but_pkg::OFF_CONTROL1, 32'h0000_0010);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0000);
    snap();
    wr(but_pkg::OFF_CONTROL, 32'h0000_0001);
    repeat (4) @(posedge clk);
    chk("trg_start", 32'd1, n_trg - s_trg);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0000);
  endtask : t_inhibit

  task automatic t_oneshot();
    wr(but_pkg::OFF_RELOAD, 32'h0000_0004);
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0009);
    repeat (30) @(posedge clk);
    rd(but_pkg::OFF_CONTROL);
    chk("enable_dropped", 32'h0000_0008, rdv);
    rd(but_pkg::OFF_COUNT);
    chk("count_stopped", 32'h0, rdv);
  endtask : t_oneshot

  // buffered reload: first wrap at the old value, then the new one holds
  task automatic t_buffer();
    wr(but_pkg::OFF_CONTROL, 32'h0000_0080);
    wr(but_pkg::OFF_RELOAD, 32'h0000_0004);
    wr(but_pkg::OFF_SWEVENT, 32'h0000_0001);
    wr(but_pkg::OFF_FLAG, 32'h0000_0000);
    wr(but_pkg::OFF_RELOAD, 32'h0000_00FF);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0081);
    repeat (20) @(posedge clk);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0080);
    rd(but_pkg::OFF_FLAG);
    chk("flag_buffered", 32'h1, rdv);
    rd(but_pkg::OFF_COUNT);
    chk("count_buffered", 32'h1, {31'h0, rdv >= 32'd16 && rdv <= 32'd20});
  endtask : t_buffer

  task automatic t_freeze();
    wr(but_pkg::OFF_CONTROL, 32'h0000_0000);
    wr(but_pkg::OFF_RELOAD, 32'h0000_FFFF);
    wr(but_pkg::OFF_DEBUG, 32'h0000_0001);
    core_halted <= 1'b1;
    repeat (8) @(posedge clk);
    wr(but_pkg::OFF_CONTROL, 32'h0000_0001);
    rd(but_pkg::OFF_COUNT);
    v1 = rdv;
    repeat (20) @(posedge clk);
    rd(but_pkg::OFF_COUNT);
    chk("count_frozen", v1, rdv);
    core_halted <= 1'b0;
    repeat (20) @(posedge clk);
    rd(but_pkg::OFF_COUNT);
    chk("count_resumed", 32'h1, {31'h0, rdv !== v1});
  endtask : t_freeze

  // ==========================================================
  // main sequence
  initial begin
    rst = 1'b1;
    core_halted = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_wrap();
    t_prescale();
    t_force();
    t_inhibit();
    t_oneshot();
    t_buffer();
    t_freeze();
    stop_test();
  end
endmodule : but_timer_tb_top
